// >>> dv/dtf_checker.sv
// port assertions for the task file block
`timescale 1ns/100ps
`default_nettype none
module dtf_checker (
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic [2:0] hostAddr,
	input wire logic       hostCsN,
	input wire logic       hostReN,
	input wire logic       hostWeN,
	input wire logic [7:0] hostDataOut,
	input wire logic       hostDataOe,
	input wire logic       runLengthDetect,
	input wire logic       readGate,
	input wire logic       markBad,
	input wire logic       selectLatchEnable,
	input wire logic       stepOut,
	input wire logic       autoScanSeek
);
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	addr_zero_quiet_a:
	assert property ((hostAddr == 3'h0) [*5] |-> !hostDataOe)
		else $error("bus driven at address zero");
	no_read_quiet_a:
	assert property (hostReN [*5] |-> !hostDataOe)
		else $error("bus driven without read");
	read_drives_a:
	assert property ((!hostCsN && !hostReN && hostAddr != 3'h0) [*5] |-> hostDataOe)
		else $error("register read not driven");
	err_gap_zero_a:
	assert property ((!hostCsN && !hostReN && hostAddr == 3'h1) [*5] |-> !hostDataOut[3])
		else $error("unused error bit set");
	latch_one_a:
	assert property (selectLatchEnable |=> !selectLatchEnable)
		else $error("latch enable too long");
	latch_cause_a:
	assert property (selectLatchEnable |-> $past(hostAddr, 2) == 3'h6 && !$past(hostWeN, 2))
		else $error("latch enable without head write");
	gate_after_run_a:
	assert property ($rose(readGate) |-> $past(runLengthDetect, 4) && $past(runLengthDetect, 100))
		else $error("read gate before run");
	gate_back_off_a:
	assert property (readGate && markBad |=> !readGate [*8])
		else $error("read gate kept after bad mark");
	step_pulse_a:
	assert property (stepOut |=> !stepOut [*8])
		else $error("step pulses too close");
	scan_pulse_a:
	assert property (autoScanSeek |=> !autoScanSeek)
		else $error("auto scan pulse too long");
endmodule
bind dtf_task_file_read_gate dtf_checker dtf_checker_i (.clock, .sys_rst, .hostAddr, .hostCsN,
	.hostReN, .hostWeN, .hostDataOut, .hostDataOe, .runLengthDetect, .readGate, .markBad,
	.selectLatchEnable, .stepOut, .autoScanSeek);
`default_nettype wire

// >>> dv/dtf_drive_model.sv
// drive and data separator model: bit clock, run detect, select latch
`timescale 1ns/100ps
`default_nettype none
module dtf_drive_model (
	input  wire logic       run,
	input  wire logic       selectLatchEnable,
	input  wire logic [7:0] hostDataIn,
	output logic            readClk,
	output logic            runLengthDetect,
	output logic      [7:0] headLatch
);
	// bit clock free running, phase unrelated to the system clock
	initial
	begin
		readClk = 1'b0;
		forever #37 readClk = ~readClk;
	end
	always @(posedge readClk) runLengthDetect <= run;
	always @(posedge selectLatchEnable) headLatch <= hostDataIn;
endmodule
`default_nettype wire

// >>> dv/dtf_task_file_read_gate_test.sv
// bench for the task file block
`timescale 1ns/100ps
`default_nettype none
module dtf_task_file_read_gate_test;
	logic        clock, sys_rst, masterReset, hostCsN, hostReN, hostWeN, hostDataOe;
	logic        readClk, runLengthDetect, readGate, driveReadyIn, writeFaultIn, trackZeroIn;
	logic        seekCompleteIn, reducedWriteCurrent, selectLatchEnable, stepOut, autoScanSeek;
	logic        run;
	logic [2:0]  hostAddr;
	logic [7:0]  hostDataIn, hostDataOut, headLatch;
	logic [9:0]  ev;
	int          fails, checks_done, cyc, n, nScan, nStep;
	// threshold, cylinder low, cylinder high, reduced current
	logic [24:0] pt [4] = '{{8'h01, 8'h04, 8'h00, 1'b1}, {8'h01, 8'h03, 8'h00, 1'b0},
		{8'hff, 8'hff, 8'h07, 1'b0}, {8'h00, 8'h00, 8'h00, 1'b1}};
	// ready, fault, command, status
	logic [17:0] at [3] = '{{2'b00, 8'h70, 8'h11}, {2'b11, 8'h70, 8'h71},
		{2'b10, 8'hf0, 8'h51}};

	dtf_task_file_read_gate dtf_task_file_read_gate_i (.clock, .sys_rst, .masterReset,
		.hostAddr, .hostCsN, .hostReN, .hostWeN, .hostDataIn, .hostDataOut, .hostDataOe,
		.readClk, .runLengthDetect, .readGate, .driveReadyIn, .writeFaultIn, .trackZeroIn,
		.seekCompleteIn, .reducedWriteCurrent, .selectLatchEnable, .stepOut, .autoScanSeek,
		.hdrFound(ev[0]), .hdrMiss(ev[1]), .hdrCylinder(11'h000), .badBlockMark(ev[2]),
		.markValid(ev[3]), .markBad(ev[4]), .dataCheckErr(ev[5]), .correctOk(ev[6]),
		.correctFail(ev[7]), .dataMarkMiss(ev[8]), .sectorDone(ev[9]));
	dtf_drive_model dtf_drive_model_i (.run, .selectLatchEnable, .hostDataIn, .readClk,
		.runLengthDetect, .headLatch);

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(negedge clock) if (autoScanSeek === 1'b1) nScan++;
	always @(negedge clock) if (stepOut === 1'b1) nStep++;
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 12000)
		begin
			fails++;
			results();
		end
	end

	task automatic results();
		if (fails == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge clock);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clock);
		hostAddr = a;
		hostDataIn = d;
		hostCsN = 1'b0;
		hostWeN = 1'b0;
		tick(4);
		hostWeN = 1'b1;
		tick(4);
		hostCsN = 1'b1;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic o);
		@(negedge clock);
		hostAddr = a;
		hostCsN = 1'b0;
		hostReN = 1'b0;
		tick(5);
		chk({7'h0, hostDataOe}, {7'h0, o});
		if (o)
			chk(hostDataOut, e);
		hostReN = 1'b1;
		hostCsN = 1'b1;
		tick(4);
	endtask
	task automatic pulse(input logic [9:0] m);
		@(negedge clock);
		ev = m;
		@(negedge clock);
		ev = 10'h000;
		tick(3);
	endtask
	task automatic wait_gate();
		n = 0;
		while (readGate !== 1'b1 && n < 400)
		begin
			tick(1);
			n++;
		end
		chk({7'h0, readGate}, 8'h01);
	endtask

	initial
	begin
		sys_rst = 1'b1;
		{masterReset, hostAddr, hostDataIn, writeFaultIn, run, ev} = '0;
		{hostCsN, hostReN, hostWeN, driveReadyIn, trackZeroIn, seekCompleteIn} = '1;
		tick(4);
		sys_rst = 1'b0;
		for (int i = 2; i <= 5; i++)
			wr(3'(i), 8'(i));
		masterReset = 1'b1;
		tick(6);
		masterReset = 1'b0;
		tick(4);
		for (int i = 2; i <= 5; i++)
			rd(3'(i), 8'(i), 1'b1);
		rd(3'h0, 8'h00, 1'b0);
		wr(3'h6, 8'h2b);
		chk(headLatch, 8'h2b);
		for (int i = 0; i < 4; i++)
		begin
			wr(3'h1, pt[i][24:17]);
			wr(3'h4, pt[i][16:9]);
			wr(3'h5, pt[i][8:1]);
			wr(3'h7, 8'h70);
			tick(3);
			chk({7'h0, reducedWriteCurrent}, {7'h0, pt[i][0]});
		end
		for (int i = 0; i < 3; i++)
		begin
			{driveReadyIn, writeFaultIn} = at[i][17:16];
			wr(3'h7, at[i][15:8]);
			rd(3'h1, 8'h04, 1'b1);
			rd(3'h7, at[i][7:0], 1'b1);
		end
		{driveReadyIn, writeFaultIn} = 2'b10;
		wr(3'h7, 8'h70);
		rd(3'h1, 8'h00, 1'b1);
		trackZeroIn = 1'b0;
		wr(3'h7, 8'h10);
		tick(700);
		trackZeroIn = 1'b1;
		tick(5);
		rd(3'h7, 8'h50, 1'b1);
		chk(8'(nStep), 8'h02);
		for (int t = 0; t < 4; t++)
		begin
			wr(3'h7, {t[1] ? 4'h4 : 4'h2, 3'h0, t[0]});
			repeat ((t[0] ? 2 : (t[1] ? 10 : 20)) - 1) pulse(10'h002);
			rd(3'h7, 8'hd2, 1'b1);
			pulse(10'h002);
			rd(3'h1, 8'h10, 1'b1);
			rd(3'h7, 8'h51, 1'b1);
		end
		chk(8'(nScan), 8'h01);
		wr(3'h7, 8'h20);
		run = 1'b1;
		wait_gate();
		chk({7'h0, n > 110}, 8'h01);
		run = 1'b0;
		tick(14);
		chk({7'h0, readGate}, 8'h00);
		run = 1'b1;
		wait_gate();
		pulse(10'h010);
		tick(80);
		chk({7'h0, readGate}, 8'h00);
		wait_gate();
		pulse(10'h008);
		run = 1'b0;
		tick(600);
		chk({7'h0, readGate}, 8'h01);
		pulse(10'h005);
		pulse(10'h100);
		chk({7'h0, readGate}, 8'h00);
		rd(3'h1, 8'h81, 1'b1);
		rd(3'h7, 8'h51, 1'b1);
		wr(3'h7, 8'h22);
		pulse(10'h001);
		pulse(10'h020);
		pulse(10'h200);
		rd(3'h1, 8'h00, 1'b1);
		rd(3'h7, 8'h50, 1'b1);
		wr(3'h7, 8'h24);
		pulse(10'h001);
		pulse(10'h020);
		pulse(10'h001);
		pulse(10'h200);
		pulse(10'h001);
		pulse(10'h200);
		rd(3'h1, 8'h40, 1'b1);
		rd(3'h7, 8'h50, 1'b1);
		rd(3'h2, 8'h00, 1'b1);
		rd(3'h3, 8'h05, 1'b1);
		wr(3'h7, 8'h20);
		for (int i = 0; i < 11; i++)
		begin
			pulse(10'h001);
			pulse(10'h020);
			if (i == 9)
				rd(3'h7, 8'hd2, 1'b1);
		end
		rd(3'h7, 8'h51, 1'b1);
		wr(3'h6, 8'hab);
		wr(3'h7, 8'h20);
		pulse(10'h001);
		pulse(10'h020);
		repeat (9) pulse(10'h080);
		rd(3'h7, 8'hd2, 1'b1);
		pulse(10'h080);
		rd(3'h7, 8'h51, 1'b1);
		wr(3'h7, 8'h20);
		pulse(10'h001);
		pulse(10'h020);
		pulse(10'h040);
		pulse(10'h200);
		rd(3'h7, 8'h54, 1'b1);
		rd(3'h1, 8'h40, 1'b1);
		wr(3'h6, 8'h2b);
		rd(3'h7, 8'h50, 1'b1);
		wr(3'h7, 8'h24);
		pulse(10'h001);
		pulse(10'h200);
		rd(3'h7, 8'hd2, 1'b1);
		masterReset = 1'b1;
		tick(6);
		masterReset = 1'b0;
		tick(4);
		rd(3'h2, 8'hff, 1'b1);
		results();
	end
endmodule
`default_nettype wire

// >>> logic/dtf_byte_timer.sv
// byte-time ticks from the separator read clock, run detect sync
`include "dtf_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module dtf_byte_timer
	import dtf_pkg::*;
#(
	parameter int BITS_PER_BYTE = `DTF_BITS_PER_BYTE
)(
	input  wire logic   clock,
	input  wire logic   sys_rst,
	input  wire logic   readClk,
	input  wire logic   runLengthDetect,
	dtf_gate_if.timer   g
);
	logic [1:0] clkSync;
	logic [1:0] runSync;
	logic       clkLast;
	logic [3:0] bitCnt;
	logic       tick;
	wire        clkRise = clkSync[1] && !clkLast;
	wire        byteEnd = clkRise && (bitCnt == 4'(BITS_PER_BYTE - 1));

	generate
		if (BITS_PER_BYTE < 2 || BITS_PER_BYTE > 16)
			$error("bits per byte out of range");
	endgenerate

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			clkSync <= 2'h0;
			runSync <= 2'h0;
			clkLast <= 1'b0;
			bitCnt  <= 4'h0;
			tick    <= 1'b0;
		end
		else
		begin
			clkSync <= {clkSync[0], readClk};
			runSync <= {runSync[0], runLengthDetect};
			clkLast <= clkSync[1];
			bitCnt  <= byteEnd ? 4'h0 : (clkRise ? bitCnt + 4'h1 : bitCnt);
			tick    <= byteEnd;
		end
	end

	assign g.byteTick = tick;
	assign g.runDet   = runSync[1];
endmodule
`default_nettype wire

// >>> logic/dtf_consts.svh
// constants for the task file, sequencer and read gate
`ifndef DTF_CONSTS_SVH
`define DTF_CONSTS_SVH
`define DTF_A_NONE        3'h0
`define DTF_A_ERR         3'h1
`define DTF_A_SCNT        3'h2
`define DTF_A_SNUM        3'h3
`define DTF_A_CYLLO       3'h4
`define DTF_A_CYLHI       3'h5
`define DTF_A_DRVHEAD     3'h6
`define DTF_A_CMD         3'h7
`define DTF_E_BAD_BLOCK   7
`define DTF_E_DATA        6
`define DTF_E_HDR_NF      4
`define DTF_E_ABORT       2
`define DTF_E_HOME        1
`define DTF_E_MARK_MISS   0
`define DTF_ERR_MASK      8'hd7
`define DTF_DRVHEAD_ECC   7
`define DTF_CMD_T         0
`define DTF_CMD_L         1
`define DTF_CMD_M         2
`define DTF_OP_RESTORE    4'h1
`define DTF_OP_READ       4'h2
`define DTF_OP_WRITE      4'h3
`define DTF_OP_SCAN       4'h4
`define DTF_OP_SEEK       4'h7
`define DTF_TASK_RST      8'h00
`define DTF_PRECOMP_RST   8'hff
`define DTF_PRECOMP_OFF   8'hff
`define DTF_TRIES_RETRY   10
`define DTF_TRIES_NORETRY 2
`define DTF_RESTORE_STEPS 2047
`define DTF_RUN_BYTES     2
`define DTF_HOLD_BYTES    7
`define DTF_BACK_BYTES    2
`define DTF_BITS_PER_BYTE 8
`define DTF_CLK_NS        10
`define DTF_STEP_NS       3000
`define DTF_STEP_CYC      ((`DTF_STEP_NS + `DTF_CLK_NS - 1) / `DTF_CLK_NS)
`endif

// >>> logic/dtf_gate_if.sv
// read gate signals between sequencer, byte timer and gate
`timescale 1ns/100ps
`default_nettype none
interface dtf_gate_if;
	logic byteTick;
	logic runDet;
	logic searchEn;
	logic markValid;
	logic markBad;
	logic readGate;
	modport timer (output byteTick, output runDet);
	modport gate (input byteTick, input runDet, input searchEn, input markValid,
		input markBad, output readGate);
	modport ctl (output searchEn, output markValid, output markBad, input readGate);
endinterface
`default_nettype wire

// >>> logic/dtf_pkg.sv
// shared state types of the task file block
package dtf_pkg;
	typedef enum logic [2:0] {
		SEQ_IDLE    = 3'b000,
		SEQ_RESTORE = 3'b001,
		SEQ_SEARCH  = 3'b010,
		SEQ_AUTO    = 3'b011,
		SEQ_DATA    = 3'b100
	} dtf_seq_t;
	typedef enum logic [2:0] {
		GATE_IDLE = 3'b000,
		GATE_RUN  = 3'b001,
		GATE_OPEN = 3'b010,
		GATE_BACK = 3'b011,
		GATE_LOCK = 3'b100
	} dtf_gate_t;
endpackage

// >>> logic/dtf_read_gate.sv
// read gate sequencing from run detect and address mark results
`include "dtf_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module dtf_read_gate
	import dtf_pkg::*;
#(
	parameter int RUN_BYTES  = `DTF_RUN_BYTES,
	parameter int HOLD_BYTES = `DTF_HOLD_BYTES,
	parameter int BACK_BYTES = `DTF_BACK_BYTES
)(
	input  wire logic   clock,
	input  wire logic   sys_rst,
	dtf_gate_if.gate    g
);
	dtf_gate_t  state;
	dtf_gate_t  next_state;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	wire        holdOpen = cnt < 4'(HOLD_BYTES);

	generate
		if (RUN_BYTES < 1 || RUN_BYTES > 15 || HOLD_BYTES < 1 || HOLD_BYTES > 15
			|| BACK_BYTES < 1 || BACK_BYTES > 15)
			$error("byte counts out of range");
	endgenerate

	always_comb
	begin
		next_state = state;
		next_cnt   = cnt;
		case (state)
		GATE_IDLE:
		begin
			next_state = GATE_RUN;
			next_cnt   = 4'h0;
		end
		GATE_RUN:
			if (!g.runDet)
				next_cnt = 4'h0;
			// first tick only aligns to the byte grid, so one extra is counted
			else if (g.byteTick && cnt == 4'(RUN_BYTES))
			begin
				next_state = GATE_OPEN;
				next_cnt   = 4'h0;
			end
			else if (g.byteTick)
				next_cnt = cnt + 4'h1;
		GATE_OPEN:
			if (g.markValid)
				next_state = GATE_LOCK;
			else if (g.markBad)
			begin
				next_state = GATE_BACK;
				next_cnt   = 4'h0;
			end
			else if (!g.runDet && holdOpen)
			begin
				next_state = GATE_RUN;
				next_cnt   = 4'h0;
			end
			else if (g.byteTick && holdOpen)
				next_cnt = cnt + 4'h1;
		GATE_BACK:
			if (g.byteTick && cnt == 4'(BACK_BYTES))
			begin
				next_state = GATE_RUN;
				next_cnt   = 4'h0;
			end
			else if (g.byteTick)
				next_cnt = cnt + 4'h1;
		GATE_LOCK:
			next_state = GATE_LOCK;
		default:
			next_state = GATE_IDLE;
		endcase
		if (!g.searchEn)
		begin
			next_state = GATE_IDLE;
			next_cnt   = 4'h0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state <= GATE_IDLE;
			cnt   <= 4'h0;
		end
		else
		begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	// gate low in every state that is not examining data
	assign g.readGate = (state == GATE_OPEN) || (state == GATE_LOCK);
endmodule
`default_nettype wire

// >>> logic/dtf_task_file_read_gate.sv
// task file, command sequencer and drive-side strobes of the disk controller
// Behaviour
// - eight byte registers on three address lines
// - address zero leaves data bus undriven
// - master reset keeps task file contents
// - read gate low unless examining data
// - read gate after two byte times run
// - run loss before seven bytes restarts
// - bad mark drops gate two bytes
// - reduced current at four times threshold
// - threshold FF never reduces current
// - bad block mark sets bit seven
// - check mode: bit six, ten rereads
// - correction mode: bit six, ten corrections
// - long mode skips data checking
// - error bits five, three read zero
// - header miss sets bit four, sticky
// - scan: ten tries, two without retry
// - read/write: ten, auto seek, ten more
// - abort on not ready, fault, unknown
// - restore fails after 2047 steps
// - missing data mark sets bit zero
// - sector count decrements, zero means 256
// - drive/head write pulses latch enable
// - corrected bit zero outside correction mode
// - command bit zero disables retry
// - command bit one selects long mode
`include "dtf_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module dtf_task_file_read_gate
	import dtf_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        masterReset,
	input  wire logic [2:0]  hostAddr,
	input  wire logic        hostCsN,
	input  wire logic        hostReN,
	input  wire logic        hostWeN,
	input  wire logic [7:0]  hostDataIn,
	output logic      [7:0]  hostDataOut,
	output logic             hostDataOe,
	input  wire logic        readClk,
	input  wire logic        runLengthDetect,
	output logic             readGate,
	input  wire logic        driveReadyIn,
	input  wire logic        writeFaultIn,
	input  wire logic        trackZeroIn,
	input  wire logic        seekCompleteIn,
	output logic             reducedWriteCurrent,
	output logic             selectLatchEnable,
	output logic             stepOut,
	output logic             autoScanSeek,
	input  wire logic        hdrFound,
	input  wire logic        hdrMiss,
	input  wire logic [10:0] hdrCylinder,
	input  wire logic        badBlockMark,
	input  wire logic        markValid,
	input  wire logic        markBad,
	input  wire logic        dataCheckErr,
	input  wire logic        correctOk,
	input  wire logic        correctFail,
	input  wire logic        dataMarkMiss,
	input  wire logic        sectorDone
);
	localparam int         NSYNC         = 19;
	localparam logic [8:0]  STEP_LAST     = 9'(`DTF_STEP_CYC - 1);
	localparam logic [10:0] RESTORE_STEPS = 11'(`DTF_RESTORE_STEPS);
	localparam logic [3:0]  RETRY_MAX     = 4'(`DTF_TRIES_RETRY);

	generate
		if (`DTF_STEP_CYC < 1 || `DTF_STEP_CYC > 512)
			$error("step period does not fit its timer");
	endgenerate

	function automatic logic [3:0] tryLimit(input logic noRetryBit);
		tryLimit = noRetryBit ? 4'(`DTF_TRIES_NORETRY) : 4'(`DTF_TRIES_RETRY);
	endfunction

	function automatic logic opKnown(input logic [3:0] code);
		opKnown = (code == `DTF_OP_RESTORE) || (code == `DTF_OP_READ)
			|| (code == `DTF_OP_WRITE) || (code == `DTF_OP_SCAN)
			|| (code == `DTF_OP_SEEK);
	endfunction

	// pin synchronisers; host strobes, address and data travel together
	logic [NSYNC-1:0] syncA;
	logic [NSYNC-1:0] syncB;
	logic             weLast;
	wire  [NSYNC-1:0] pinVec = {hostAddr, hostCsN, hostReN, hostWeN, hostDataIn,
		masterReset, driveReadyIn, writeFaultIn, trackZeroIn, seekCompleteIn};
	wire  [2:0]       addrS   = syncB[18:16];
	wire              csNS    = syncB[15];
	wire              reNS    = syncB[14];
	wire              weNS    = syncB[13];
	wire  [7:0]       dataS   = syncB[12:5];
	wire              mstRstS = syncB[4];
	wire              readyS  = syncB[3];
	wire              faultS  = syncB[2];
	wire              homeS   = syncB[1];
	wire              seekS   = syncB[0];

	// task file
	logic [7:0]  precompCyl;
	logic [7:0]  sectorCount;
	logic [7:0]  sectorNumber;
	logic [7:0]  cylLow;
	logic [7:0]  cylHigh;
	logic [7:0]  sizeDriveHeadReg;
	logic [7:0]  commandCode;
	logic [7:0]  errorFlags;
	logic [7:0]  next_precompCyl;
	logic [7:0]  next_sectorCount;
	logic [7:0]  next_sectorNumber;
	logic [7:0]  next_cylLow;
	logic [7:0]  next_cylHigh;
	logic [7:0]  next_sizeDriveHeadReg;
	logic [7:0]  next_commandCode;
	logic [7:0]  next_errorFlags;

	// sequencer
	dtf_seq_t    seqState;
	dtf_seq_t    next_seqState;
	logic [3:0]  tries;
	logic [3:0]  next_tries;
	logic [3:0]  dataTries;
	logic [3:0]  next_dataTries;
	logic        phase2;
	logic        next_phase2;
	logic [10:0] stepCnt;
	logic [10:0] next_stepCnt;
	logic [8:0]  stepTmr;
	logic [8:0]  next_stepTmr;
	logic [10:0] presentCyl;
	logic [10:0] next_presentCyl;
	logic        statErr;
	logic        next_statErr;
	logic        corrected;
	logic        next_corrected;
	logic        next_stepPulse;
	logic [7:0]  readMux;

	wire         selected   = !csNS && (addrS != `DTF_A_NONE);
	wire         busy       = seqState != SEQ_IDLE;
	wire         wrStb      = selected && !weNS && weLast && !busy;
	wire         rdActive   = selected && !reNS;
	wire         wrCmd      = wrStb && (addrS == `DTF_A_CMD);
	wire         wrHead     = wrStb && (addrS == `DTF_A_DRVHEAD);
	wire  [3:0]  newOp      = dataS[7:4];
	wire  [3:0]  op         = commandCode[7:4];
	wire         isScan     = op == `DTF_OP_SCAN;
	wire         noRetry    = commandCode[`DTF_CMD_T];
	wire         longMode   = commandCode[`DTF_CMD_L];
	wire         multi      = commandCode[`DTF_CMD_M];
	wire         eccMode    = sizeDriveHeadReg[`DTF_DRVHEAD_ECC];
	wire  [3:0]  tryMax     = tryLimit(noRetry);
	wire  [10:0] cylTarget  = {cylHigh[2:0], cylLow};
	wire  [7:0]  sectorLeft = sectorCount - 8'h01;
	wire  [7:0]  errView    = errorFlags & `DTF_ERR_MASK;
	wire  [7:0]  statusView = {busy, readyS, faultS, seekS, 1'b0,
		corrected && eccMode, busy, statErr};
	wire  [10:0] rwcStart   = {1'b0, precompCyl, 2'b00};
	wire         rwcOn      = (precompCyl != `DTF_PRECOMP_OFF) && (presentCyl >= rwcStart);

	dtf_gate_if gif ();

	dtf_byte_timer u_timer (
		.clock           (clock),
		.sys_rst         (sys_rst),
		.readClk         (readClk),
		.runLengthDetect (runLengthDetect),
		.g               (gif.timer)
	);

	dtf_read_gate u_gate (
		.clock   (clock),
		.sys_rst (sys_rst),
		.g       (gif.gate)
	);

	assign gif.searchEn  = (seqState == SEQ_SEARCH) || (seqState == SEQ_DATA);
	assign gif.markValid = markValid;
	assign gif.markBad   = markBad;
	assign readGate      = gif.readGate;
	assign autoScanSeek  = seqState == SEQ_AUTO;

	// while busy every nonzero address, the command slot included, answers with status
	always_comb
	begin
		case (addrS)
		`DTF_A_ERR:     readMux = errView;
		`DTF_A_SCNT:    readMux = sectorCount;
		`DTF_A_SNUM:    readMux = sectorNumber;
		`DTF_A_CYLLO:   readMux = cylLow;
		`DTF_A_CYLHI:   readMux = cylHigh;
		`DTF_A_DRVHEAD: readMux = sizeDriveHeadReg;
		default:        readMux = statusView;
		endcase
		if (busy)
			readMux = statusView;
	end

	always_comb
	begin
		next_precompCyl       = precompCyl;
		next_sectorCount      = sectorCount;
		next_sectorNumber     = sectorNumber;
		next_cylLow           = cylLow;
		next_cylHigh          = cylHigh;
		next_sizeDriveHeadReg = sizeDriveHeadReg;
		next_commandCode      = commandCode;
		next_errorFlags       = errorFlags;
		next_seqState         = seqState;
		next_tries            = tries;
		next_dataTries        = dataTries;
		next_phase2           = phase2;
		next_stepCnt          = stepCnt;
		next_stepTmr          = stepTmr;
		next_presentCyl       = presentCyl;
		next_statErr          = statErr;
		next_corrected        = corrected;
		next_stepPulse        = 1'b0;
		if (wrStb)
		begin
			case (addrS)
			`DTF_A_ERR:     next_precompCyl = dataS;
			`DTF_A_SCNT:    next_sectorCount = dataS;
			`DTF_A_SNUM:    next_sectorNumber = dataS;
			`DTF_A_CYLLO:   next_cylLow = dataS;
			`DTF_A_CYLHI:   next_cylHigh = dataS;
			`DTF_A_DRVHEAD: next_sizeDriveHeadReg = dataS;
			default:        next_commandCode = dataS;
			endcase
		end
		if (badBlockMark && busy)
			next_errorFlags[`DTF_E_BAD_BLOCK] = 1'b1;
		case (seqState)
		SEQ_IDLE:
			if (wrCmd)
			begin
				next_errorFlags = 8'h00;
				next_statErr    = 1'b0;
				next_corrected  = 1'b0;
				next_tries      = 4'h0;
				next_dataTries  = 4'h0;
				next_phase2     = 1'b0;
				next_stepCnt    = 11'h000;
				next_stepTmr    = 9'h000;
				if (!readyS || faultS || !opKnown(newOp))
				begin
					next_errorFlags[`DTF_E_ABORT] = 1'b1;
					next_statErr = 1'b1;
				end
				else if (newOp == `DTF_OP_RESTORE)
					next_seqState = SEQ_RESTORE;
				else if (newOp == `DTF_OP_SEEK)
					next_presentCyl = cylTarget;
				else
				begin
					if (newOp != `DTF_OP_SCAN)
						next_presentCyl = cylTarget;
					next_seqState = SEQ_SEARCH;
				end
			end
		SEQ_RESTORE:
			if (homeS)
			begin
				next_presentCyl = 11'h000;
				next_seqState   = SEQ_IDLE;
			end
			else if (stepTmr != STEP_LAST)
				next_stepTmr = stepTmr + 9'h001;
			else if (stepCnt == RESTORE_STEPS)
			begin
				next_errorFlags[`DTF_E_HOME] = 1'b1;
				next_statErr  = 1'b1;
				next_seqState = SEQ_IDLE;
			end
			else
			begin
				next_stepTmr   = 9'h000;
				next_stepCnt   = stepCnt + 11'h001;
				next_stepPulse = 1'b1;
			end
		SEQ_SEARCH:
			if (hdrFound)
			begin
				next_tries = 4'h0;
				if (isScan)
				begin
					next_presentCyl = hdrCylinder;
					next_seqState   = SEQ_IDLE;
				end
				else
					next_seqState = SEQ_DATA;
			end
			else if (hdrMiss)
			begin
				next_errorFlags[`DTF_E_HDR_NF] = 1'b1;
				if (tries + 4'h1 < tryMax)
					next_tries = tries + 4'h1;
				else if (!isScan && !noRetry && !phase2)
				begin
					next_phase2   = 1'b1;
					next_tries    = 4'h0;
					next_seqState = SEQ_AUTO;
				end
				else
				begin
					next_statErr  = 1'b1;
					next_seqState = SEQ_IDLE;
				end
			end
		SEQ_AUTO:
		begin
			next_presentCyl = cylTarget;
			next_seqState   = SEQ_SEARCH;
		end
		SEQ_DATA:
			if (dataMarkMiss)
			begin
				next_errorFlags[`DTF_E_MARK_MISS] = 1'b1;
				next_statErr  = 1'b1;
				next_seqState = SEQ_IDLE;
			end
			else if (dataCheckErr && !longMode)
			begin
				next_errorFlags[`DTF_E_DATA] = 1'b1;
				if (noRetry)
				begin
					next_statErr  = 1'b1;
					next_seqState = SEQ_IDLE;
				end
				else if (!eccMode && dataTries == RETRY_MAX)
				begin
					next_statErr  = 1'b1;
					next_seqState = SEQ_IDLE;
				end
				else if (!eccMode)
				begin
					next_dataTries = dataTries + 4'h1;
					next_seqState  = SEQ_SEARCH;
				end
			end
			else if (correctOk && eccMode && !noRetry)
				next_corrected = 1'b1;
			else if (correctFail && eccMode && !noRetry)
			begin
				next_dataTries = dataTries + 4'h1;
				if (dataTries + 4'h1 == RETRY_MAX)
				begin
					next_statErr  = 1'b1;
					next_seqState = SEQ_IDLE;
				end
			end
			else if (sectorDone)
			begin
				next_dataTries = 4'h0;
				next_seqState  = SEQ_IDLE;
				if (multi)
				begin
					next_sectorCount  = sectorLeft;
					next_sectorNumber = sectorNumber + 8'h01;
					if (sectorLeft != 8'h00)
						next_seqState = SEQ_SEARCH;
				end
			end
		default:
			next_seqState = SEQ_IDLE;
		endcase
		// master reset stops the sequencer only; task file holds its values
		if (mstRstS)
		begin
			next_seqState  = SEQ_IDLE;
			next_stepPulse = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			syncA  <= '1;
			syncB  <= '1;
			weLast <= 1'b1;
		end
		else
		begin
			syncA  <= pinVec;
			syncB  <= syncA;
			weLast <= weNS;
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			precompCyl       <= `DTF_PRECOMP_RST;
			sectorCount      <= `DTF_TASK_RST;
			sectorNumber     <= `DTF_TASK_RST;
			cylLow           <= `DTF_TASK_RST;
			cylHigh          <= `DTF_TASK_RST;
			sizeDriveHeadReg <= `DTF_TASK_RST;
			commandCode      <= `DTF_TASK_RST;
			errorFlags       <= `DTF_TASK_RST;
		end
		else
		begin
			precompCyl       <= next_precompCyl;
			sectorCount      <= next_sectorCount;
			sectorNumber     <= next_sectorNumber;
			cylLow           <= next_cylLow;
			cylHigh          <= next_cylHigh;
			sizeDriveHeadReg <= next_sizeDriveHeadReg;
			commandCode      <= next_commandCode;
			errorFlags       <= next_errorFlags;
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			seqState   <= SEQ_IDLE;
			tries      <= 4'h0;
			dataTries  <= 4'h0;
			phase2     <= 1'b0;
			stepCnt    <= 11'h000;
			stepTmr    <= 9'h000;
			presentCyl <= 11'h000;
			statErr    <= 1'b0;
			corrected  <= 1'b0;
		end
		else
		begin
			seqState   <= next_seqState;
			tries      <= next_tries;
			dataTries  <= next_dataTries;
			phase2     <= next_phase2;
			stepCnt    <= next_stepCnt;
			stepTmr    <= next_stepTmr;
			presentCyl <= next_presentCyl;
			statErr    <= next_statErr;
			corrected  <= next_corrected;
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hostDataOut         <= 8'h00;
			hostDataOe          <= 1'b0;
			reducedWriteCurrent <= 1'b0;
			selectLatchEnable   <= 1'b0;
			stepOut             <= 1'b0;
		end
		else
		begin
			hostDataOut         <= readMux;
			hostDataOe          <= rdActive;
			reducedWriteCurrent <= rwcOn;
			selectLatchEnable   <= wrHead;
			stepOut             <= next_stepPulse;
		end
	end
endmodule
`default_nettype wire
